// ---- hdl/rfevt_prescaler.sv ----
/*
  Timer clock divider: chip clock enable from ref_clk, then 2**exponent.
  Assumes exponent held stable by the register file.
*/
module rfevt_prescaler (
  input  wire logic  ref_clk,  // system clock
  input  wire logic  reset_n,  // async reset, low
  rfevt_tmr_if.psc   tif       // divider link
);
  import rfevt_pkg::*;

  logic [17:0]      acc_r, acc_nxt, acc_sum;
  logic [DIV_W-1:0] div_r, div_nxt, limit;
  logic             tick_r, tick_nxt, chip_en;
  logic [4:0]       exp_c;

  // ==========================================================
  // next state: fractional chip clock, then power of two divide
  always_comb begin
    acc_sum  = acc_r + 18'(CHIP_CLK_KHZ);
    chip_en  = (acc_sum >= 18'(REF_CLK_KHZ));
    acc_nxt  = chip_en ? 18'(acc_sum - 18'(REF_CLK_KHZ)) : acc_sum;
    exp_c    = (tif.exponent > MAX_EXPONENT) ? MAX_EXPONENT : tif.exponent;
    limit    = DIV_W'((DIV_W'(1) << exp_c) - DIV_W'(1));
    div_nxt  = div_r;
    tick_nxt = 1'b0;
    if (tif.restart) begin
      div_nxt = '0;
    end else if (chip_en) begin
      if (div_r >= limit) begin
        div_nxt  = '0;
        tick_nxt = 1'b1;
      end else begin
        div_nxt = div_r + DIV_W'(1);
      end
    end
  end

  // registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      acc_r  <= '0;
      div_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      acc_r  <= acc_nxt;
      div_r  <= div_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tif.tick = tick_r;

  // ticks only follow a chip clock step of a full divide; a lowered
  // exponent may leave the divider above the new limit for one tick
  tick_cause_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    tick_r |-> $past(div_r) >= $past(limit) && $past(chip_en))
    else $error("timer tick without full divide");

endmodule : rfevt_prescaler

// ---- hdl/rfevt_slot_timer.sv ----
/*
  Slot period counter on the encoder clock enable; requests fifo sends.
  Assumes enc_tick is a one-cycle enable from the encoder.
*/
module rfevt_slot_timer (
  input  wire logic  ref_clk,  // system clock
  input  wire logic  reset_n,  // async reset, low
  rfevt_tmr_if.slot  tif       // slot link
);
  import rfevt_pkg::*;

  logic [SLOT_W-1:0] cnt_r, cnt_nxt;
  logic              active_r, active_nxt, send_r, send_nxt, nz;

  // ==========================================================
  // next state: count interval..0, restart while interval nonzero
  always_comb begin
    nz         = (tif.slot_interval != '0);
    cnt_nxt    = cnt_r;
    active_nxt = active_r;
    send_nxt   = 1'b0;
    if (tif.cmd_done && nz) begin
      cnt_nxt    = tif.slot_interval;
      active_nxt = 1'b1;
    end else if (active_r && tif.enc_tick) begin
      if (cnt_r == '0) begin
        send_nxt = tif.fifo_not_empty && nz;
        if (nz) begin
          cnt_nxt = tif.slot_interval;
        end else begin
          active_nxt = 1'b0;
        end
      end else begin
        cnt_nxt = cnt_r - SLOT_W'(1);
      end
    end
  end

  // registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_r    <= '0;
      active_r <= 1'b0;
      send_r   <= 1'b0;
    end else begin
      cnt_r    <= cnt_nxt;
      active_r <= active_nxt;
      send_r   <= send_nxt;
    end
  end

  assign tif.send_req    = send_r;
  assign tif.slot_active = active_r;

  send_gate_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    send_r |-> $past(tif.fifo_not_empty) && $past(active_r)
               && $past(cnt_r) == '0)
    else $error("send without data or before period end");
  zero_block_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    send_r |-> $past(tif.slot_interval) != '0)
    else $error("send with zero slot interval");
  slot_cov: cover property (@(posedge ref_clk) disable iff (!reset_n)
    send_r ##[1:1000] send_r);

endmodule : rfevt_slot_timer

// ---- hdl/rfevt_timer.sv ----
/*
  Reader event timer: host registers, start/stop event logic, 8-bit
  down-counter, expiry pulse and slot period sending.
  Assumes host strobes are one-cycle pulses synchronous to ref_clk and
  that the interrupt request register outside collects the expiry pulse.
*/
module rfevt_timer (
  input  wire  logic       ref_clk,               // 125 MHz clock
  input  wire  logic       reset_n,               // async reset, low
  input  wire  logic [5:0] host_addr,             // register offset
  input  wire  logic [7:0] host_wdata,            // write data
  input  wire  logic       host_wr_en,            // write strobe
  input  wire  logic       host_rd_en,            // read strobe
  output logic       [7:0] host_rdata,            // read data, next cycle
  input  wire  logic       tx_first_bit_event,    // first bit sent
  input  wire  logic       tx_last_bit_event,     // last bit sent
  input  wire  logic       rx_first_bit_event,    // first valid bit in
  input  wire  logic       rx_last_bit_event,     // last bit in
  input  wire  logic       cmd_done,              // command finished
  input  wire  logic       enc_tick,              // encoder clock enable
  input  wire  logic       fifo_not_empty,        // fifo holds data
  input  wire  logic [7:0] slot_interval_lo,      // slot interval low
  input  wire  logic       slot_interval_top_bit, // slot interval bit 8
  output logic             counting_flag,         // timer running
  output logic       [7:0] live_count,            // current count
  output logic             count_expired_irq,     // expiry pulse
  output logic             frame_send_req         // auto send pulse
);
  import rfevt_pkg::*;

  rfevt_tmr_if tif ();

  rfevt_state_t state_r, state_nxt;
  logic [7:0]   count_r, count_nxt;
  logic         irq_r, irq_nxt;
  logic [5:0]   div_cfg_r, div_cfg_nxt;
  logic [3:0]   evt_sel_r, evt_sel_nxt;
  logic [7:0]   load_r, load_nxt;
  logic [7:0]   rdata_r, rdata_nxt;
  logic         sw_start, sw_stop, start_evt, stop_evt, tick, run;
  logic         wr_ctrl, auto_rl;

  // ==========================================================
  // sub blocks
  assign tif.exponent       = div_cfg_r[4:0];
  assign tif.restart        = start_evt;
  assign tif.slot_interval  = {slot_interval_top_bit, slot_interval_lo};
  assign tif.cmd_done       = cmd_done;
  assign tif.enc_tick       = enc_tick;
  assign tif.fifo_not_empty = fifo_not_empty;
  assign tick               = tif.tick;

  rfevt_prescaler u_psc (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .tif     (tif.psc)
  );

  rfevt_slot_timer u_slot (
    .ref_clk (ref_clk),
    .reset_n (reset_n),
    .tif     (tif.slot)
  );

  // ==========================================================
  // event decode
  assign wr_ctrl   = host_wr_en && (host_addr == ADDR_CTRL);
  assign sw_start  = wr_ctrl && host_wdata[CTRL_SW_START_BIT];
  assign sw_stop   = wr_ctrl && host_wdata[CTRL_SW_STOP_BIT];
  assign auto_rl   = div_cfg_r[CFG_AUTO_BIT];
  assign run       = (state_r == ST_RUN);
  assign start_evt = sw_start
                   || (tx_first_bit_event && evt_sel_r[SEL_START_TX1])
                   || (tx_last_bit_event  && evt_sel_r[SEL_START_TXN]);
  assign stop_evt  = sw_stop
                   || (rx_first_bit_event && evt_sel_r[SEL_STOP_RX1])
                   || (rx_last_bit_event  && evt_sel_r[SEL_STOP_RXN]);

  // ==========================================================
  // register file next values
  always_comb begin
    div_cfg_nxt = div_cfg_r;
    evt_sel_nxt = evt_sel_r;
    load_nxt    = load_r;
    rdata_nxt   = rdata_r;
    if (host_wr_en) begin
      case (host_addr)
        ADDR_DIV_CFG: div_cfg_nxt = host_wdata[5:0];
        ADDR_EVT_SEL: evt_sel_nxt = host_wdata[3:0];
        ADDR_LOAD:    load_nxt    = host_wdata;
        default:      ;
      endcase
    end
    if (host_rd_en) begin
      case (host_addr)
        ADDR_SEC_FLAGS: rdata_nxt = {run, 7'h00};
        ADDR_LIVE:      rdata_nxt = count_r;
        ADDR_DIV_CFG:   rdata_nxt = {2'h0, div_cfg_r};
        ADDR_EVT_SEL:   rdata_nxt = {4'h0, evt_sel_r};
        ADDR_LOAD:      rdata_nxt = load_r;
        default:        rdata_nxt = 8'h00;
      endcase
    end
  end

  // register file
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_cfg_r <= RST_DIV_CFG;
      evt_sel_r <= RST_EVT_SEL;
      load_r    <= RST_LOAD;
      rdata_r   <= 8'h00;
    end else begin
      div_cfg_r <= div_cfg_nxt;
      evt_sel_r <= evt_sel_nxt;
      load_r    <= load_nxt;
      rdata_r   <= rdata_nxt;
    end
  end

  // ==========================================================
  // down-counter next state; stop beats start for state and irq, start still loads the count; both beat tick
  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r;
    irq_nxt   = 1'b0;
    case (state_r)
      ST_IDLE: ;
      ST_RUN: begin
        if (tick) begin
          if (count_r == 8'h01) begin
            irq_nxt = 1'b1;
            if (auto_rl) begin
              count_nxt = load_r;
            end else begin
              count_nxt = 8'h00;
              state_nxt = ST_IDLE;
            end
          end else if (count_r != 8'h00) begin
            count_nxt = count_r - 8'h01;
          end
        end
      end
      default: state_nxt = ST_IDLE;
    endcase
    if (start_evt) begin
      count_nxt = load_r;
      irq_nxt   = 1'b0;
      state_nxt = (load_r != 8'h00) ? ST_RUN : ST_IDLE;
    end
    if (stop_evt) begin
      state_nxt = ST_IDLE;
      irq_nxt   = 1'b0;
      if (!start_evt) begin
        count_nxt = count_r;
      end
    end
  end

  // counter registers
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_r <= ST_IDLE;
      count_r <= 8'h00;
      irq_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      count_r <= count_nxt;
      irq_r   <= irq_nxt;
    end
  end

  // outputs
  assign host_rdata        = rdata_r;
  assign counting_flag     = state_r[1];
  assign live_count        = count_r;
  assign count_expired_irq = irq_r;
  assign frame_send_req    = tif.send_req;

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  logic quiet;
  assign quiet = !start_evt && !stop_evt;

  dec_step_a: assert property (run && tick && quiet && count_r > 8'h01
    |=> count_r == 8'($past(count_r) - 8'h01))
    else $error("count did not step down by one");
  auto_reload_a: assert property (run && tick && quiet && auto_rl
    && count_r == 8'h01 |=> run && count_r == $past(load_r))
    else $error("auto reload did not reload");
  start_load_a: assert property (start_evt && !stop_evt
    |=> count_r == $past(load_r) && run == ($past(load_r) != 8'h00))
    else $error("start did not load the count");
  retrigger_a: assert property (run && start_evt && !stop_evt
    |=> count_r == $past(load_r))
    else $error("running timer not retriggered");
  stop_halt_a: assert property (stop_evt |=> !run ##1 !run || start_evt)
    else $error("stop event did not halt the timer");
  hold_count_a: assert property (host_wr_en && host_addr == ADDR_LOAD
    && quiet && !tick |=> count_r == $past(count_r))
    else $error("load write disturbed the count");
  sw_stop_a: assert property (sw_stop |=> !count_expired_irq)
    else $error("software stop raised expiry");
  expiry_irq_a: assert property (run && tick && quiet && count_r == 8'h01
    |=> count_expired_irq)
    else $error("expiry pulse missing");
  irq_cause_a: assert property (count_expired_irq
    |-> $past(count_r) == 8'h01 && $past(tick) && $past(run))
    else $error("expiry pulse without step from one");
  zero_start_a: assert property (start_evt && !stop_evt && load_r == 8'h00
    |=> !run && count_r == 8'h00 && !count_expired_irq)
    else $error("zero load did not stay stopped");
  flag_read_a: assert property (host_rd_en && host_addr == ADDR_SEC_FLAGS
    |=> host_rdata[SEC_RUN_BIT] == $past(run))
    else $error("secondary flags read wrong running bit");
  live_read_a: assert property (host_rd_en && host_addr == ADDR_LIVE
    |=> host_rdata == $past(count_r))
    else $error("live count read mismatch");

  oneshot_cov: cover property (start_evt ##[1:300] count_expired_irq);
  periodic_cov: cover property (count_expired_irq && auto_rl
    ##[1:1000] count_expired_irq);
  stopwatch_cov: cover property (run && stop_evt && !sw_stop);
  send_cov: cover property (frame_send_req);

endmodule : rfevt_timer

// ---- inc/rfevt_pkg.sv ----
/*
  Constants, register map and state type of the reader event timer.
  Assumes a 125 MHz ref_clk and an 8-bit host register port.
*/
package rfevt_pkg;

  // ==========================================================
  // register offsets
  localparam logic [5:0] ADDR_SEC_FLAGS = 6'h05;
  localparam logic [5:0] ADDR_CTRL      = 6'h09;
  localparam logic [5:0] ADDR_LIVE      = 6'h0c;
  localparam logic [5:0] ADDR_DIV_CFG   = 6'h2a;
  localparam logic [5:0] ADDR_EVT_SEL   = 6'h2b;
  localparam logic [5:0] ADDR_LOAD      = 6'h2c;

  // ==========================================================
  // field positions
  localparam int SEC_RUN_BIT       = 7;
  localparam int CTRL_SW_START_BIT = 1;
  localparam int CTRL_SW_STOP_BIT  = 2;
  localparam int CFG_AUTO_BIT      = 5;
  localparam int SEL_START_TX1     = 0;
  localparam int SEL_START_TXN     = 1;
  localparam int SEL_STOP_RX1      = 2;
  localparam int SEL_STOP_RXN      = 3;

  // ==========================================================
  // values after reset
  localparam logic [5:0] RST_DIV_CFG = 6'h00;
  localparam logic [3:0] RST_EVT_SEL = 4'h0;
  localparam logic [7:0] RST_LOAD    = 8'h00;

  // ==========================================================
  // clocking: chip clock made from ref_clk by a phase accumulator
  localparam int REF_CLK_KHZ  = 125000;
  localparam int CHIP_CLK_KHZ = 13560;
  localparam logic [4:0] MAX_EXPONENT = 5'd21;
  localparam int DIV_W  = 22;
  localparam int SLOT_W = 9;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } rfevt_state_t;

endpackage : rfevt_pkg

// ---- inc/rfevt_tmr_if.sv ----
/*
  Carrier between the timer core, its prescaler and the slot timer.
  Assumes all signals are synchronous to ref_clk.
*/
interface rfevt_tmr_if;
  logic [4:0] exponent;       // divider exponent
  logic       restart;        // realign divider
  logic       tick;           // timer clock enable
  logic [8:0] slot_interval;  // nine bit slot interval
  logic       cmd_done;       // command finished
  logic       enc_tick;       // encoder clock enable
  logic       fifo_not_empty; // fifo holds data
  logic       send_req;       // send pulse
  logic       slot_active;    // period running

  modport psc      (input exponent, restart, output tick);
  modport psc_user (output exponent, restart, input tick);
  modport slot     (input slot_interval, cmd_done, enc_tick, fifo_not_empty,
                    output send_req, slot_active);
  modport slot_user(output slot_interval, cmd_done, enc_tick, fifo_not_empty,
                    input send_req, slot_active);
endinterface : rfevt_tmr_if

// ---- sim/rfevt_timer_bench.sv ----
/*
  Self-checking bench of the reader event timer: registers, start and
  stop events, expiry, auto reload and slot period sending.
  Assumes the package and design files are compiled before it.
*/
module rfevt_timer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import rfevt_pkg::*;

  logic        ref_clk, reset_n, host_wr_en, host_rd_en;
  logic [5:0]  host_addr;
  logic [7:0]  host_wdata, host_rdata, live_count, slot_lo;
  logic        tx1, txn, rx1, rxn, cmd_done, enc_tick, fifo_ne, slot_top;
  logic        counting_flag, count_expired_irq, frame_send_req;
  logic        rd_d, enc_on;
  logic [1:0]  enc_div;
  logic [31:0] rnd;
  int          cyc, irq_seen, mismatches, check_count;
  logic [7:0]  exp_q[$];
  int          send_t[$];

  rfevt_timer dut (.ref_clk(ref_clk), .reset_n(reset_n),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_wr_en(host_wr_en),
    .host_rd_en(host_rd_en), .host_rdata(host_rdata),
    .tx_first_bit_event(tx1), .tx_last_bit_event(txn),
    .rx_first_bit_event(rx1), .rx_last_bit_event(rxn),
    .cmd_done(cmd_done), .enc_tick(enc_tick), .fifo_not_empty(fifo_ne),
    .slot_interval_lo(slot_lo), .slot_interval_top_bit(slot_top),
    .counting_flag(counting_flag), .live_count(live_count),
    .count_expired_irq(count_expired_irq), .frame_send_req(frame_send_req));

  // ==========================================================
  // clock, 8 ns period
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  // ==========================================================
  // compare, verdict and random source
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : report_and_stop

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  // ==========================================================
  // monitor: oldest read note against data, event counters
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    rd_d <= host_rd_en;
    if (count_expired_irq === 1'b1) irq_seen <= irq_seen + 1;
    if (frame_send_req === 1'b1) send_t.push_back(cyc);
  end
  always @(negedge ref_clk) begin
    if (rd_d === 1'b1 && exp_q.size() > 0) begin
      check(host_rdata, exp_q.pop_front());
    end
  end

  // encoder clock enable, one pulse every 4 cycles
  always @(posedge ref_clk) begin
    enc_div <= enc_div + 2'd1;
    enc_tick <= enc_on && (enc_div == 2'd3);
  end

  // ==========================================================
  // drivers
  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cycles

  task automatic reg_write(input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    host_addr <= a;
    host_wdata <= d;
    host_wr_en <= 1'b1;
    @(posedge ref_clk);
    host_wr_en <= 1'b0;
    @(negedge ref_clk);
  endtask : reg_write

  task automatic reg_read(input logic [5:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    host_addr <= a;
    host_rd_en <= 1'b1;
    exp_q.push_back(e);
    @(posedge ref_clk);
    host_rd_en <= 1'b0;
    @(negedge ref_clk);
  endtask : reg_read

  task automatic pulse(input int k);
    @(posedge ref_clk);
    case (k)
      0: tx1 <= 1'b1;
      1: txn <= 1'b1;
      2: rx1 <= 1'b1;
      3: rxn <= 1'b1;
      default: cmd_done <= 1'b1;
    endcase
    @(posedge ref_clk);
    {tx1, txn, rx1, rxn, cmd_done} <= 5'h00;
    @(negedge ref_clk);
  endtask : pulse

  // waits for the flag to drop, each count step must be one down
  task automatic wait_stop(input int bound);
    logic [7:0] prev;
    prev = live_count;
    for (int i = 0; i < bound; i++) begin
      @(negedge ref_clk);
      if (live_count !== prev) check(live_count, prev - 8'd1);
      prev = live_count;
      if (counting_flag === 1'b0) return;
    end
    mismatches++;
    report_and_stop();
  endtask : wait_stop

  task automatic wait_sends(input int n, input int bound);
    for (int i = 0; i < bound && send_t.size() < n; i++) cycles(1);
    if (send_t.size() < n) begin
      mismatches++;
      report_and_stop();
    end
  endtask : wait_sends

  // ==========================================================
  // main sequence
  initial begin
    int t0, e, lo, hi, irq0;
    logic [7:0] held;
    {reset_n, host_wr_en, host_rd_en, tx1, txn, rx1, rxn} = 7'h00;
    {cmd_done, enc_tick, fifo_ne, slot_top, rd_d, enc_on} = 6'h00;
    {host_addr, host_wdata, slot_lo, enc_div} = 24'h000000;
    cyc = 0;
    irq_seen = 0;
    mismatches = 0;
    check_count = 0;
    rnd = 32'he6f8;
    cycles(2);
    reset_n <= 1'b1;
    // reset values, masks, unmapped and write-only places
    reg_read(ADDR_DIV_CFG, 8'h00);
    reg_read(ADDR_EVT_SEL, 8'h00);
    reg_read(ADDR_LOAD, 8'h00);
    reg_read(ADDR_SEC_FLAGS, 8'h00);
    reg_read(6'h3f, 8'h00);
    reg_write(ADDR_DIV_CFG, 8'hff);
    reg_write(ADDR_EVT_SEL, 8'hff);
    reg_read(ADDR_DIV_CFG, 8'h3f);
    reg_read(ADDR_EVT_SEL, 8'h0f);
    reg_read(ADDR_CTRL, 8'h00);
    reg_write(ADDR_EVT_SEL, 8'h00);
    // expiry period for several exponents, random load
    for (int x = 0; x < 3; x++) begin
      rnd = lfsr_next(rnd);
      reg_write(ADDR_DIV_CFG, 8'(x));
      reg_write(ADDR_LOAD, 8'd2 + {6'h00, rnd[1:0]});
      irq0 = irq_seen;
      reg_write(ADDR_CTRL, 8'h02);
      t0 = cyc;
      check(live_count, 8'd2 + {6'h00, rnd[1:0]});
      reg_read(ADDR_SEC_FLAGS, 8'h80);
      wait_stop(3000);
      e = (2 + int'(rnd[1:0])) * (1 << x);
      lo = (e - 1) * REF_CLK_KHZ / CHIP_CLK_KHZ;
      hi = e * REF_CLK_KHZ / CHIP_CLK_KHZ + 3;
      check(8'(cyc - t0 >= lo && cyc - t0 <= hi), 8'h01);
      cycles(2);
      check(8'(irq_seen - irq0), 8'h01);
      check(live_count, 8'h00);
      reg_read(ADDR_LIVE, 8'h00);
    end
    reg_write(ADDR_DIV_CFG, 8'h00);
    // frame events, selected and unselected
    reg_write(ADDR_LOAD, 8'd200);
    for (int k = 0; k < 2; k++) begin
      reg_write(ADDR_EVT_SEL, 8'(4'h5 << k));
      pulse(1 - k);
      check(8'(counting_flag), 8'h00);
      irq0 = irq_seen;
      pulse(k);
      check(8'(counting_flag), 8'h01);
      cycles(30);
      pulse(k + 2);
      held = live_count;
      check(8'(counting_flag), 8'h00);
      cycles(30);
      check(live_count, held);
      check(8'(irq_seen - irq0), 8'h00);
      reg_read(ADDR_SEC_FLAGS, 8'h00);
    end
    // retrigger, load change while counting, software stop
    reg_write(ADDR_LOAD, 8'd100);
    reg_write(ADDR_CTRL, 8'h02);
    cycles(40);
    reg_write(ADDR_LOAD, 8'd10);
    reg_write(ADDR_DIV_CFG, 8'h01);
    check(8'(live_count > 8'd80), 8'h01);
    reg_write(ADDR_CTRL, 8'h02);
    check(live_count, 8'd10);
    irq0 = irq_seen;
    cycles(20);
    reg_write(ADDR_CTRL, 8'h04);
    check(8'(counting_flag), 8'h00);
    cycles(40);
    check(8'(irq_seen - irq0), 8'h00);
    // auto reload: two expiries, count never reaches zero
    reg_write(ADDR_DIV_CFG, 8'h20);
    reg_write(ADDR_LOAD, 8'd3);
    irq0 = irq_seen;
    reg_write(ADDR_CTRL, 8'h02);
    for (int i = 0; i < 200 && irq_seen - irq0 < 2; i++) begin
      @(negedge ref_clk);
      if (live_count === 8'h00) check(live_count, 8'h01);
    end
    check(8'(irq_seen - irq0), 8'h02);
    check(8'(counting_flag), 8'h01);
    reg_write(ADDR_CTRL, 8'h04);
    // zero load value start
    reg_write(ADDR_LOAD, 8'h00);
    irq0 = irq_seen;
    reg_write(ADDR_CTRL, 8'h02);
    cycles(30);
    check(8'(counting_flag), 8'h00);
    check(live_count, 8'h00);
    check(8'(irq_seen - irq0), 8'h00);
    // slot period: spacing, change mid-period, empty fifo, zero, nine bits
    enc_on <= 1'b1;
    fifo_ne <= 1'b1;
    slot_lo <= 8'd3;
    pulse(4);
    wait_sends(1, 100);
    slot_lo <= 8'd5;
    wait_sends(3, 200);
    check(8'(send_t[1] - send_t[0]), 8'd16);
    check(8'(send_t[2] - send_t[1]), 8'd24);
    fifo_ne <= 1'b0;
    cycles(60);
    check(8'(send_t.size()), 8'd3);
    slot_lo <= 8'h00;
    cycles(30);
    fifo_ne <= 1'b1;
    cycles(100);
    check(8'(send_t.size()), 8'd3);
    pulse(4);
    cycles(40);
    check(8'(send_t.size()), 8'd3);
    slot_top <= 1'b1;
    pulse(4);
    wait_sends(5, 2400);
    check(8'((send_t[4] - send_t[3]) == 1028), 8'h01);
    cycles(4);
    report_and_stop();
  end
endmodule : rfevt_timer_bench
